// file: core/sync_event_cfg.svh
`ifndef SYNC_EVENT_CFG_SVH
`define SYNC_EVENT_CFG_SVH

// Register addresses on the register port
`define ADDR_PULSE_COUNT 9'h13e
`define ADDR_GENERAL_CTRL 9'h143
`define ADDR_OUTPUT_EXCLUDE 9'h144
`define ADDR_W 9

// Power-on values
`define GENERAL_CTRL_RST 8'h01
`define OUTPUT_EXCLUDE_RST 8'h00
`define PULSE_COUNT_RST 8'h00

// Field positions
`define BIT_REF_CLEAR 7
`define BIT_EDGE_SELECT 6
`define BIT_PIN_INVERT 5
`define BIT_FUNC_ENABLE 4
`define BIT_LOOP2_HOLD 3
`define BIT_LOOP1_HOLD 2
`define BIT_REF_EXCLUDE 7

// Timing
`define CLK_PERIOD_NS 100
`define ONESHOT_TIME_NS 400
`define ONESHOT_CYC ((`ONESHOT_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define PULSE_TICK_DIV 2
`define NUM_DEV_OUT 7

`endif

// file: core/sync_event_pkg.sv
package sync_event_pkg;

  // Source select of the general control register
  typedef enum logic [1:0] {
    MODE_OFF,
    MODE_PIN,
    MODE_PULSER_PIN,
    MODE_PULSER_REG
  } src_mode_t;

  // General control register layout
  typedef struct packed {
    logic ref_clear;
    logic edge_trigger_select;
    logic pin_invert;
    logic func_enable;
    logic loop2_lock_hold;
    logic loop1_lock_hold;
    src_mode_t mode;
  } ctrl_t;

  // Exclusion register layout
  typedef struct packed {
    logic reference_pulse_exclude;
    logic [6:0] output_exclude;
  } excl_t;

  // Pulse generator states
  typedef enum logic [1:0] {
    PS_IDLE,
    PS_HIGH,
    PS_LOW
  } pulser_state_t;

endpackage

// file: core/ref_pulser.sv
`timescale 1ns/1ps
`default_nettype none
`include "sync_event_cfg.svh"

// Emits a train of pulses; each high and low phase lasts one divider tick
module ref_pulser #(
  parameter int TICK_DIV = `PULSE_TICK_DIV
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Request
  input wire logic start,
  input wire logic [7:0] count,
  // Pulse train
  output logic pulse,
  output logic busy
);

  generate
    if (TICK_DIV < 1 || TICK_DIV > 255) begin : g_bad_div
      $error("ref_pulser: TICK_DIV out of range");
    end
  endgenerate

  localparam logic [7:0] TICK_LAST = 8'(TICK_DIV - 1);

  sync_event_pkg::pulser_state_t state_ff; // Current phase
  sync_event_pkg::pulser_state_t nxt_state;
  logic [7:0] tdiv_ff; // Tick divider
  logic [7:0] remain_ff; // Pulses still to send
  logic tick; // One-cycle enable at the slow rate
  logic take; // Start accepted

  assign tick = (tdiv_ff == TICK_LAST);
  // A start while busy is ignored so a train is never cut short
  assign take = start && (state_ff == sync_event_pkg::PS_IDLE);

  // Divider restarts on an accepted start so the first pulse width is exact
  always_ff @(posedge clk) begin
    if (rst || take || tick) begin
      tdiv_ff <= 8'h00;
    end else begin
      tdiv_ff <= tdiv_ff + 8'h01;
    end
  end

  // Next phase
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      sync_event_pkg::PS_IDLE: begin
        if (take) begin
          nxt_state = sync_event_pkg::PS_HIGH;
        end
      end
      sync_event_pkg::PS_HIGH: begin
        if (tick) begin
          nxt_state = sync_event_pkg::PS_LOW;
        end
      end
      sync_event_pkg::PS_LOW: begin
        if (tick) begin
          nxt_state = (remain_ff == 8'h01) ? sync_event_pkg::PS_IDLE : sync_event_pkg::PS_HIGH;
        end
      end
      default: begin
        nxt_state = sync_event_pkg::PS_IDLE;
      end
    endcase
  end

  // Phase register
  always_ff @(posedge clk) begin
    if (rst) begin
      state_ff <= sync_event_pkg::PS_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Pulse counter; a count of zero still sends one pulse
  always_ff @(posedge clk) begin
    if (rst) begin
      remain_ff <= 8'h00;
    end else if (take) begin
      remain_ff <= (count == 8'h00) ? 8'h01 : count;
    end else if (state_ff == sync_event_pkg::PS_LOW && tick) begin
      remain_ff <= remain_ff - 8'h01;
    end
  end

  // Outputs straight from flops
  always_ff @(posedge clk) begin
    if (rst) begin
      pulse <= 1'b0;
      busy <= 1'b0;
    end else begin
      pulse <= (nxt_state == sync_event_pkg::PS_HIGH);
      busy <= (nxt_state != sync_event_pkg::PS_IDLE);
    end
  end

endmodule // ref_pulser
`default_nettype wire

// file: core/sync_event_control.sv
`timescale 1ns/1ps
`default_nettype none
`include "sync_event_cfg.svh"

// Notes on behaviour
// - Edge select 0: hold while input asserted
// - Edge select 1: rising edge, fixed hold
// - Pin inverted by bit 5; bit 4 enables
// - Loop-2 hold keeps sync until locked
// - Loop-1 hold keeps sync until locked
// - Source 0: nothing raises a sync event
// - Source 1: pin or lock holds raise sync
// - Source 2: pin or holds trigger pulse train
// - Source 3: pulse-count write triggers pulse train
// - Reference exclude keeps reference dividers running
// - Output exclude keeps that output untouched
module sync_event_control #(
  parameter int NUM_OUT = `NUM_DEV_OUT,
  parameter int ONESHOT_CYC = `ONESHOT_CYC,
  parameter int TICK_DIV = `PULSE_TICK_DIV
) (
  // Clock and reset
  input wire logic CLK_SYS,
  input wire logic SYS_RST,
  // Register port
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire logic [`ADDR_W-1:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  output logic [7:0] REG_RDATA,
  // Synchronization pin and lock flags
  input wire logic SYNC_PIN,
  input wire logic LOOP1_DIGITAL_LOCK_DETECT,
  input wire logic LOOP2_DIGITAL_LOCK_DETECT,
  // Divider controls
  output logic [NUM_OUT-1:0] DEVICE_CLOCK_OUTPUT_HOLD,
  output logic REF_DIV_HOLD,
  output logic REF_PULSE,
  output logic REFERENCE_PULSE_CLEAR,
  output logic SYNC_BUSY
);

  generate
    if (NUM_OUT != 7 || ONESHOT_CYC < 1 || ONESHOT_CYC > 255) begin : g_bad_param
      $error("sync_event_control: unsupported parameter value");
    end
  endgenerate

  localparam logic [7:0] ONESHOT_LOAD = 8'(ONESHOT_CYC);

  // Address match, shared by write and read decode
  function automatic logic hit(input logic [`ADDR_W-1:0] a, input logic [`ADDR_W-1:0] t);
    hit = (a == t);
  endfunction

  sync_event_pkg::ctrl_t ctrl_ff; // General control register
  sync_event_pkg::excl_t excl_ff; // Exclusion register
  logic [7:0] pcount_ff; // Pulse count register
  logic [NUM_OUT-1:0] part_ff; // Outputs taking part, frozen per event
  logic ref_part_ff; // Reference dividers taking part
  logic active_ff; // Event in progress
  logic pin_prev_ff; // Pin level one cycle back
  logic src_prev_ff; // Combined trigger level one cycle back
  logic [7:0] oneshot_ff; // Edge-mode hold counter
  logic pin_act; // Pin after optional inversion
  logic lock_req; // Lock-hold request
  logic pin_rise; // Rising edge of the pin
  logic oneshot_on; // Edge-mode hold running
  logic level_req; // Source-1 request
  logic src_now; // Trigger source for source 2
  logic pulse_start; // Start the pulse generator
  logic pulser_pulse; // Pulse generator output
  logic pulser_busy; // Pulse generator running
  logic sync_req; // Sync wanted this cycle
  logic pc_write; // Write to the pulse count register

  // Pin and lock sources, all gated by the function enable
  assign pin_act = SYNC_PIN ^ ctrl_ff.pin_invert;
  assign lock_req = (ctrl_ff.loop1_lock_hold && !LOOP1_DIGITAL_LOCK_DETECT)
      || (ctrl_ff.loop2_lock_hold && !LOOP2_DIGITAL_LOCK_DETECT);
  assign pin_rise = pin_act && !pin_prev_ff;
  assign oneshot_on = (oneshot_ff != 8'h00);
  // Level or one-shot pin term, or lock hold
  assign level_req = ctrl_ff.func_enable
      && ((ctrl_ff.edge_trigger_select ? oneshot_on : pin_act) || lock_req);
  assign src_now = ctrl_ff.func_enable && (pin_act || lock_req);
  assign pc_write = REG_WR && hit(REG_ADDR, `ADDR_PULSE_COUNT);

  // Pulse generator trigger picks the source by mode
  always_comb begin
    pulse_start = 1'b0;
    unique case (ctrl_ff.mode)
      sync_event_pkg::MODE_PULSER_PIN: pulse_start = src_now && !src_prev_ff;
      sync_event_pkg::MODE_PULSER_REG: pulse_start = pc_write && ctrl_ff.func_enable;
      sync_event_pkg::MODE_OFF, sync_event_pkg::MODE_PIN: pulse_start = 1'b0;
    endcase
  end

  // Sync request by mode
  always_comb begin
    sync_req = 1'b0;
    unique case (ctrl_ff.mode)
      sync_event_pkg::MODE_OFF: sync_req = 1'b0;
      sync_event_pkg::MODE_PIN: sync_req = level_req;
      sync_event_pkg::MODE_PULSER_PIN: sync_req = pulser_pulse;
      sync_event_pkg::MODE_PULSER_REG: sync_req = pulser_pulse;
    endcase
  end

  ref_pulser #(
    .TICK_DIV(TICK_DIV)
  ) u_pulser (
    .clk(CLK_SYS),
    .rst(SYS_RST),
    .start(pulse_start),
    .count(pcount_ff),
    .pulse(pulser_pulse),
    .busy(pulser_busy)
  );

  // Register writes
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      ctrl_ff <= `GENERAL_CTRL_RST;
      excl_ff <= `OUTPUT_EXCLUDE_RST;
      pcount_ff <= `PULSE_COUNT_RST;
    end else if (REG_WR) begin
      if (hit(REG_ADDR, `ADDR_GENERAL_CTRL)) begin
        ctrl_ff <= REG_WDATA;
      end
      if (hit(REG_ADDR, `ADDR_OUTPUT_EXCLUDE)) begin
        excl_ff <= REG_WDATA;
      end
      if (pc_write) begin
        pcount_ff <= REG_WDATA;
      end
    end
  end

  // Read data, one cycle after the strobe; unmapped addresses read zero
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      REG_RDATA <= 8'h00;
    end else if (REG_RD) begin
      if (hit(REG_ADDR, `ADDR_GENERAL_CTRL)) begin
        REG_RDATA <= ctrl_ff;
      end else if (hit(REG_ADDR, `ADDR_OUTPUT_EXCLUDE)) begin
        REG_RDATA <= excl_ff;
      end else if (hit(REG_ADDR, `ADDR_PULSE_COUNT)) begin
        REG_RDATA <= pcount_ff;
      end else begin
        REG_RDATA <= 8'h00;
      end
    end
  end

  // Edge history for pin and pulser trigger
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      pin_prev_ff <= 1'b0;
      src_prev_ff <= 1'b0;
    end else begin
      pin_prev_ff <= pin_act;
      src_prev_ff <= src_now;
    end
  end

  // One-shot hold; a fresh edge restarts the full minimum time
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      oneshot_ff <= 8'h00;
    end else if (pin_rise && ctrl_ff.edge_trigger_select && ctrl_ff.func_enable) begin
      oneshot_ff <= ONESHOT_LOAD;
    end else if (oneshot_on) begin
      oneshot_ff <= oneshot_ff - 8'h01;
    end
  end

  // Participants are frozen at event start so a mid-event write to the
  // exclusion register cannot split the release
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      active_ff <= 1'b0;
      part_ff <= '0;
      ref_part_ff <= 1'b0;
    end else begin
      active_ff <= sync_req;
      if (sync_req && !active_ff) begin
        part_ff <= ~excl_ff.output_exclude;
        ref_part_ff <= ~excl_ff.reference_pulse_exclude;
      end
    end
  end

  // Divider holds: one request drives every participant, so all release together
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      DEVICE_CLOCK_OUTPUT_HOLD <= '0;
      REF_DIV_HOLD <= 1'b0;
    end else if (!sync_req) begin
      DEVICE_CLOCK_OUTPUT_HOLD <= '0;
      REF_DIV_HOLD <= 1'b0;
    end else if (active_ff) begin
      DEVICE_CLOCK_OUTPUT_HOLD <= part_ff;
      REF_DIV_HOLD <= ref_part_ff;
    end else begin
      DEVICE_CLOCK_OUTPUT_HOLD <= ~excl_ff.output_exclude;
      REF_DIV_HOLD <= ~excl_ff.reference_pulse_exclude;
    end
  end

  // Status and pulse outputs; the clear bit is passed through as programmed
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      REF_PULSE <= 1'b0;
      REFERENCE_PULSE_CLEAR <= 1'b0;
      SYNC_BUSY <= 1'b0;
    end else begin
      REF_PULSE <= pulser_pulse;
      REFERENCE_PULSE_CLEAR <= ctrl_ff.ref_clear;
      SYNC_BUSY <= sync_req || pulser_busy;
    end
  end

  // Checks
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (SYS_RST);

  sequence s_pin_edge;
    ctrl_ff.mode == sync_event_pkg::MODE_PIN && ctrl_ff.func_enable
        && ctrl_ff.edge_trigger_select && pin_rise;
  endsequence

  sequence s_pulse_soon;
    ##[1:4] REF_PULSE;
  endsequence

  a_mode_off_quiet: assert property (ctrl_ff.mode == sync_event_pkg::MODE_OFF
      && !$past(sync_req) |=> DEVICE_CLOCK_OUTPUT_HOLD == '0 && !REF_DIV_HOLD)
    else $error("hold raised with source off");
  a_level_holds: assert property (ctrl_ff.mode == sync_event_pkg::MODE_PIN
      && ctrl_ff.func_enable && !ctrl_ff.edge_trigger_select && pin_act
      && !active_ff |=> DEVICE_CLOCK_OUTPUT_HOLD == ~$past(excl_ff.output_exclude))
    else $error("level sync did not hold outputs");
  a_oneshot_time: assert property (s_pin_edge |=> oneshot_on [*4])
    else $error("one-shot hold too short");
  a_disable_quiet: assert property (ctrl_ff.mode == sync_event_pkg::MODE_PIN
      && !ctrl_ff.func_enable |=> !active_ff)
    else $error("sync active while disabled");
  a_invert_pin: assert property (ctrl_ff.mode == sync_event_pkg::MODE_PIN
      && ctrl_ff.func_enable && !ctrl_ff.edge_trigger_select && ctrl_ff.pin_invert
      && !SYNC_PIN |=> active_ff)
    else $error("inverted pin did not sync");
  a_loop2_hold: assert property (ctrl_ff.mode == sync_event_pkg::MODE_PIN
      && ctrl_ff.func_enable && ctrl_ff.loop2_lock_hold
      && !LOOP2_DIGITAL_LOCK_DETECT |=> active_ff)
    else $error("loop-2 hold not kept");
  a_loop1_hold: assert property (ctrl_ff.mode == sync_event_pkg::MODE_PIN
      && ctrl_ff.func_enable && ctrl_ff.loop1_lock_hold
      && !LOOP1_DIGITAL_LOCK_DETECT |=> active_ff)
    else $error("loop-1 hold not kept");
  a_pin_pulser: assert property (ctrl_ff.mode == sync_event_pkg::MODE_PULSER_PIN
      && pulse_start && !pulser_busy |-> s_pulse_soon)
    else $error("pin trigger gave no pulse");
  a_write_pulser: assert property (ctrl_ff.mode == sync_event_pkg::MODE_PULSER_REG
      && ctrl_ff.func_enable && pc_write && !pulser_busy |-> s_pulse_soon)
    else $error("count write gave no pulse");
  a_ref_exclude: assert property (sync_req && !active_ff
      && excl_ff.reference_pulse_exclude |=> !REF_DIV_HOLD)
    else $error("excluded reference divider held");
  a_out_exclude: assert property (sync_req && !active_ff |=>
      (DEVICE_CLOCK_OUTPUT_HOLD & $past(excl_ff.output_exclude)) == '0)
    else $error("excluded output held");
  a_release_together: assert property (DEVICE_CLOCK_OUTPUT_HOLD != '0
      && $past(DEVICE_CLOCK_OUTPUT_HOLD) != '0
      |-> DEVICE_CLOCK_OUTPUT_HOLD == $past(DEVICE_CLOCK_OUTPUT_HOLD))
    else $error("participants changed mid-event");

endmodule // sync_event_control
`default_nettype wire

// file: tb/sync_pin_host.sv
`timescale 1ns/1ps
`default_nettype none

// Host logic that owns the synchronization pin
module sync_pin_host (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Level the bench asks for
  input wire logic want,
  // Pin into the device
  output logic pin
);
  // Pin moves only at a clock edge, so it never glitches inside a cycle
  always_ff @(posedge clk) begin
    if (rst) begin
      pin <= 1'b0;
    end else begin
      pin <= want;
    end
  end
endmodule // sync_pin_host

`default_nettype wire

// file: tb/sync_event_control_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "sync_event_cfg.svh"
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin bad_count++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, (a), (e)); end end

module sync_event_control_tb_top;
  // Bench-driven inputs
  logic clk, rst, wr, rd, want, l1, l2, pin;
  logic [8:0] addr;
  logic [7:0] wd, rdat, ex, cnt;
  // Device outputs
  logic [6:0] hold;
  logic refh, rp, clr, busy, prev;
  // Counters
  int bad_count, checks_done, cyc, n;

  sync_event_control dut (.CLK_SYS(clk), .SYS_RST(rst), .REG_WR(wr), .REG_RD(rd),
    .REG_ADDR(addr), .REG_WDATA(wd), .REG_RDATA(rdat), .SYNC_PIN(pin),
    .LOOP1_DIGITAL_LOCK_DETECT(l1), .LOOP2_DIGITAL_LOCK_DETECT(l2),
    .DEVICE_CLOCK_OUTPUT_HOLD(hold), .REF_DIV_HOLD(refh), .REF_PULSE(rp),
    .REFERENCE_PULSE_CLEAR(clr), .SYNC_BUSY(busy));

  sync_pin_host host (.clk(clk), .rst(rst), .want(want), .pin(pin));

  // 10 MHz system clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // Hang guard: the whole sequence needs well under 3000 cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      finish_test();
    end
  end

  // Verdict and end of run
  task finish_test();
    $display("bad_count=%0d checks_done=%0d", bad_count, checks_done);
    if (bad_count == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Step k edges, then settle 1 ns so drives never race the edge
  task tick(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask

  // One-cycle register write, then one idle edge so a following write
  // never raises the strobe in the step that lowered it
  task wreg(input logic [8:0] a, input logic [7:0] d);
    addr = a;
    wd = d;
    wr = 1'b1;
    tick(1);
    wr = 1'b0;
    tick(1);
  endtask

  // Register read; data is looked at one cycle late, it stands until the next read
  task rchk(input logic [8:0] a, input logic [7:0] e);
    addr = a;
    rd = 1'b1;
    tick(1);
    rd = 1'b0;
    tick(1);
    `CHK(rdat, e)
  endtask

  // Count pulses of one train, checking divider holds while each pulse is high
  task train();
    n = 0;
    prev = 1'b0;
    repeat (120) begin
      tick(1);
      if (rp === 1'b1 && prev !== 1'b1) n++;
      if (rp === 1'b1) `CHK({refh, hold}, ~ex)
      prev = rp;
    end
  endtask

  // General control value built from its fields
  function logic [7:0] ctl(input logic eg, inv, en, h2, h1, input sync_event_pkg::src_mode_t m);
    return {1'b0, eg, inv, en, h2, h1, m};
  endfunction

  // Pulses expected from a count value: zero still gives one
  function int pulses(input logic [7:0] c);
    return (c == 8'h00) ? 1 : int'(c);
  endfunction

  // Main sequence
  initial begin
    void'($urandom(51144));
    {rst, wr, rd, want, l1, l2, addr, wd} = {1'b1, 5'h00, 9'h000, 8'h00};
    tick(16);
    rst = 1'b0;
    tick(1);
    // Every output still low at the first edge after release
    `CHK({refh, hold, busy, rp, clr, rdat}, 19'h00000)
    // Power-on values, unmapped read and ignored unmapped write
    rchk(`ADDR_GENERAL_CTRL, `GENERAL_CTRL_RST);
    rchk(`ADDR_PULSE_COUNT, `PULSE_COUNT_RST);
    wreg(9'h100, 8'hff);
    rchk(9'h100, 8'h00);
    rchk(`ADDR_OUTPUT_EXCLUDE, `OUTPUT_EXCLUDE_RST);
    // Clear bit is raised only for a moment, then kept zero
    wreg(`ADDR_GENERAL_CTRL, 8'h80);
    tick(2);
    `CHK(clr, 1'b1)
    wreg(`ADDR_GENERAL_CTRL, 8'h00);
    tick(1);
    `CHK(clr, 1'b0)
    // Level mode, plain and inverted pin, random exclusion and hold length
    for (int i = 0; i < 6; i++) begin
      wreg(`ADDR_GENERAL_CTRL, 8'h00);
      want = i[0];
      ex = 8'($urandom);
      wreg(`ADDR_OUTPUT_EXCLUDE, ex);
      rchk(`ADDR_OUTPUT_EXCLUDE, ex);
      wreg(`ADDR_GENERAL_CTRL, ctl(1'b0, i[0], 1'b1, 1'b0, 1'b0, sync_event_pkg::MODE_PIN));
      tick(3);
      `CHK({refh, hold, busy}, 9'h000)
      want = ~i[0];
      tick(3 + $urandom % 8);
      `CHK({refh, hold, busy}, {~ex, 1'b1})
      want = i[0];
      tick(4);
      `CHK({refh, hold}, 8'h00)
    end
    // Source off, or function disabled: pin and lock holds stay silent
    for (int i = 0; i < 3; i++) begin
      wreg(`ADDR_GENERAL_CTRL, (i == 0) ? ctl(1'b0, 1'b0, 1'b1, 1'b1, 1'b1, sync_event_pkg::MODE_OFF)
        : ctl(1'b0, 1'b0, 1'b0, 1'b1, 1'b1, sync_event_pkg::src_mode_t'(i)));
      want = 1'b1;
      tick(8);
      `CHK({refh, hold, busy, rp}, 10'h000)
      want = 1'b0;
      tick(3);
    end
    // Edge mode: a held pin gives one fixed-length hold only
    ex = 8'h00;
    wreg(`ADDR_OUTPUT_EXCLUDE, ex);
    wreg(`ADDR_GENERAL_CTRL, ctl(1'b1, 1'b0, 1'b1, 1'b0, 1'b0, sync_event_pkg::MODE_PIN));
    want = 1'b1;
    n = 0;
    repeat (20) begin
      tick(1);
      if (hold !== 7'h00) n++;
    end
    `CHK(n, `ONESHOT_CYC)
    want = 1'b0;
    tick(3);
    // Lock holds: each releases only on its own loop's lock
    for (int k = 0; k < 2; k++) begin
      wreg(`ADDR_GENERAL_CTRL, ctl(1'b0, 1'b0, 1'b1, k == 1, k == 0, sync_event_pkg::MODE_PIN));
      tick(3);
      `CHK({refh, hold}, 8'hff)
      if (k == 0) l2 = 1'b1; else l1 = 1'b1;
      tick(3);
      `CHK({refh, hold}, 8'hff)
      if (k == 0) l1 = 1'b1; else l2 = 1'b1;
      tick(3);
      `CHK({refh, hold}, 8'h00)
      wreg(`ADDR_GENERAL_CTRL, 8'h00);
      {l1, l2} = 2'b00;
    end
    // Register-started trains use the count held before the starting write
    for (int i = 0; i < 4; i++) begin
      cnt = (i == 0) ? 8'h00 : 8'(1 + $urandom % 5);
      ex = 8'($urandom);
      wreg(`ADDR_OUTPUT_EXCLUDE, ex);
      wreg(`ADDR_GENERAL_CTRL, ctl(1'b0, 1'b0, 1'b1, 1'b0, 1'b0, sync_event_pkg::MODE_OFF));
      wreg(`ADDR_PULSE_COUNT, cnt);
      wreg(`ADDR_GENERAL_CTRL, ctl(1'b0, 1'b0, 1'b1, 1'b0, 1'b0, sync_event_pkg::MODE_PULSER_REG));
      wreg(`ADDR_PULSE_COUNT, 8'h03);
      train();
      `CHK(n, pulses(cnt))
      `CHK(busy, 1'b0)
    end
    // Pin-started train with the count left at 3
    wreg(`ADDR_GENERAL_CTRL, ctl(1'b0, 1'b0, 1'b1, 1'b0, 1'b0, sync_event_pkg::MODE_PULSER_PIN));
    want = 1'b1;
    train();
    `CHK(n, 3)
    want = 1'b0;
    tick(2);
    finish_test();
  end
endmodule // sync_event_control_tb_top

`default_nettype wire
